// ===== inc/dcec_pkg.sv
// shared constants and types of the data cache and external cache controller
// Notes on behaviour
// - every store is forwarded to the external cache; the data cache is write-through
// - a store miss never allocates or fills a data cache line
// - data cache is 16 KB, direct-mapped, two separately valid 16-byte sub-blocks per line
// - index from virtual address bits, hit decided by physical tag compare
// - tags sized for a 41-bit physical address from a 44-bit virtual one
// - tag array has a fill write port beside the load read port
// - snoops look up the tags on their own second read port
// - load misses wait in a load buffer, stores in a store buffer
// - the controller serves instruction cache misses and data cache misses
// - one external cache access may start every cycle
// - external access is pipelined, three cycles pin to pin, 16 bytes per access
// - external cache sizes 512 KB, 1, 2, 4 MB; line always 64 bytes
// - external lines carry a five-state coherence state used for hit and write
// - stores hitting the external cache proceed while a load miss is outstanding
// - a read to write or write to read switch costs two idle cycles
// - tag word holds state in [24:22], address bits 40..19 in [21:0], full compare
// - external data writes use per-byte write enables
package dcec_pkg;
  localparam int VA_W     = 44;               // virtual address width
  localparam int PA_W     = 41;               // physical address width
  localparam int DATA_W   = 128;              // one sub-block, one external beat
  localparam int BE_W     = 16;               // bytes per beat
  localparam int SUB_LSB  = 4;                // sub-block select bit
  localparam int IDX_LSB  = 5;                // 32-byte line
  localparam int IDX_W    = 9;                // 512 lines
  localparam int DTAG_LSB = IDX_LSB + IDX_W;  // first physical tag bit
  localparam int DTAG_W   = PA_W - DTAG_LSB;  // physical tag width
  localparam int EC_LAT   = 3;                // pin-to-pin read latency
  localparam int SYNC_N   = 2;                // input synchroniser stages
  localparam int EC_PIPE  = EC_LAT + SYNC_N + 1;
  localparam logic [1:0] EC_TURN = 2'h2;      // idle cycles on direction change
  localparam int EC_AMSB  = 21;               // top external address bit (4 MB)
  localparam int ECD_LSB  = 4;                // data sram address from pa[21:4]
  localparam int ECD_AW   = EC_AMSB - ECD_LSB + 1;
  localparam int ECT_LSB  = 6;                // tag sram address from pa[21:6], 64-byte line
  localparam int ECT_AW   = EC_AMSB - ECT_LSB + 1;
  localparam int ECTAG_W  = 25;               // external tag word
  localparam int ECST_MSB = 24;               // coherence state field
  localparam int ECST_LSB = 22;
  localparam int ECPA_LSB = 19;               // lowest address bit held in the tag
  localparam logic [1:0] SZ_512K = 2'h0;
  localparam logic [1:0] SZ_1M   = 2'h1;
  localparam logic [1:0] SZ_2M   = 2'h2;
  localparam logic [1:0] SZ_4M   = 2'h3;
  localparam logic [2:0] ST_I = 3'h0;         // state bits are dirty, exclusive, valid
  localparam logic [2:0] ST_S = 3'h1;
  localparam logic [2:0] ST_E = 3'h3;
  localparam logic [2:0] ST_O = 3'h5;
  localparam logic [2:0] ST_M = 3'h7;
  typedef enum logic [1:0] {K_NONE, K_LD, K_IC, K_ST} dcec_kind_t;
endpackage : dcec_pkg

// ===== hw/dcec_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dcec_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // clock
  input  wire logic         rst_i,  // async reset, active high
  input  wire logic [W-1:0] d_i,    // asynchronous input
  output logic      [W-1:0] q_o     // synchronised output
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } dcec_sync_t;
  dcec_sync_t s_q;
  dcec_sync_t s_d;

  // first stage feeds only the second
  always_comb begin
    s_d.meta = d_i;
    s_d.q    = s_q.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.q;
endmodule : dcec_sync

// ===== hw/dcec_tag_ram.sv
// data cache tag array: two read ports, one fill write port, snoop invalidate
`timescale 1ns/1ps
module dcec_tag_ram #(
  parameter int IW = 9,
  parameter int TW = 27
) (
  input  wire logic          clk_i,      // clock
  input  wire logic          rst_i,      // async reset, active high
  input  wire logic [IW-1:0] a_idx_i,    // load/store lookup index
  output logic      [TW-1:0] a_tag_o,    // load/store tag
  output logic      [1:0]    a_vld_o,    // load/store sub-block valids
  input  wire logic [IW-1:0] b_idx_i,    // snoop lookup index
  output logic      [TW-1:0] b_tag_o,    // snoop tag
  output logic      [1:0]    b_vld_o,    // snoop sub-block valids
  input  wire logic          we_i,       // fill write
  input  wire logic [IW-1:0] w_idx_i,    // fill index
  input  wire logic [TW-1:0] w_tag_i,    // fill tag
  input  wire logic [1:0]    w_vld_i,    // fill valids
  input  wire logic          inv_i,      // snoop invalidate
  input  wire logic [IW-1:0] inv_idx_i   // invalidate index
);
  logic [TW-1:0] tag_mem [2**IW];
  logic [1:0]    vld_q   [2**IW];

  // independent read ports so snoops never stall loads
  assign a_tag_o = tag_mem[a_idx_i];
  assign a_vld_o = vld_q[a_idx_i];
  assign b_tag_o = tag_mem[b_idx_i];
  assign b_vld_o = vld_q[b_idx_i];

  // tag storage needs no reset, valids guard it
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      tag_mem[w_idx_i] <= w_tag_i;
    end
  end

  // per sub-block valids; invalidate after fill in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2**IW; i++) begin
        vld_q[i] <= 2'h0;
      end
    end else begin
      if (we_i) begin
        vld_q[w_idx_i] <= w_vld_i;
      end
      if (inv_i) begin
        vld_q[inv_idx_i] <= 2'h0;
      end
    end
  end
endmodule : dcec_tag_ram

// ===== hw/dcec_top.sv
// data cache, load/store buffers and second-level cache controller
`timescale 1ns/1ps
module dcec_top
  import dcec_pkg::*;
(
  input  wire logic              CLK_I,          // processor clock
  input  wire logic              RESET_I,        // async reset, active high
  input  wire logic              LS_VALID_I,     // load/store request
  input  wire logic              LS_WRITE_I,     // 1 store, 0 load
  input  wire logic [VA_W-1:0]   LS_VADDR_I,     // virtual address
  input  wire logic [PA_W-1:0]   LS_PADDR_I,     // translated address
  input  wire logic [DATA_W-1:0] LS_WDATA_I,     // store data
  input  wire logic [BE_W-1:0]   LS_BMASK_I,     // store byte mask, bit b = data[8b+7:8b]
  output logic                   LS_LD_READY_O,  // load buffer free
  output logic                   LS_ST_READY_O,  // store buffer free
  output logic                   LD_DONE_O,      // load result pulse
  output logic                   LD_EMISS_O,     // load missed external cache too
  output logic [DATA_W-1:0]      LD_DATA_O,      // load sub-block
  input  wire logic              IC_MISS_I,      // instruction cache miss request
  input  wire logic [PA_W-1:0]   IC_PADDR_I,     // miss address
  output logic                   IC_READY_O,     // miss slot free
  output logic                   IC_DONE_O,      // miss answer pulse
  output logic                   IC_HIT_O,       // external hit
  output logic [DATA_W-1:0]      IC_DATA_O,      // 16 instruction bytes
  input  wire logic              SNP_VALID_I,    // coherence snoop
  input  wire logic [VA_W-1:0]   SNP_VADDR_I,    // snoop index address
  input  wire logic [PA_W-1:0]   SNP_PADDR_I,    // snoop physical address
  output logic                   SNP_HIT_O,      // snoop hit, line invalidated
  input  wire logic [1:0]        EC_SIZE_I,      // external cache size code
  output logic                   EC_MISS_O,      // external miss or upgrade pulse
  output logic [PA_W-1:0]        EC_MISS_PA_O,   // its address
  output logic [ECD_AW-1:0]      EC_DADDR_O,     // data sram address
  output logic [ECT_AW-1:0]      EC_TADDR_O,     // tag sram address
  input  wire logic [DATA_W-1:0] EC_DATA_I,      // data bus in
  output logic [DATA_W-1:0]      EC_DATA_O,      // data bus out
  output logic                   EC_DATA_OE_O,   // data bus drive
  input  wire logic [ECTAG_W-1:0] EC_TAG_I,      // tag bus in
  output logic [ECTAG_W-1:0]     EC_TAG_O,       // tag bus out
  output logic                   EC_TAG_OE_O,    // tag bus drive
  output logic                   EC_DWR_N_O,     // data write, low
  output logic                   EC_DOE_N_O,     // data access, low
  output logic                   EC_TWR_N_O,     // tag write, low
  output logic                   EC_TOE_N_O,     // tag access, low
  output logic [BE_W-1:0]        EXT_BYTE_WE_N_O // byte enables, bit 0 = data[127:120]
);
  typedef struct packed {
    logic ld_rdy, st_rdy, ic_rdy;
    logic ld_done, ld_emiss;
    logic [DATA_W-1:0] ld_data;
    logic ic_done, ic_hit;
    logic [DATA_W-1:0] ic_data;
    logic snp_hit, ec_miss;
    logic [PA_W-1:0] ec_miss_pa;
    logic [ECD_AW-1:0] daddr;
    logic [ECT_AW-1:0] taddr;
    logic [DATA_W-1:0] dout;
    logic [ECTAG_W-1:0] tout;
    logic doe_drv, toe_drv, dwr_n, doe_n, twr_n, toe_n;
    logic [BE_W-1:0] bwe_n;
    logic ld_v, ld_iss, ld_keep;
    logic [VA_W-1:0] ld_va;
    logic [PA_W-1:0] ld_pa;
    logic st_v, st_iss, st_wr;
    logic [PA_W-1:0] st_pa;
    logic [DATA_W-1:0] st_data;
    logic [BE_W-1:0] st_mask;
    logic [2:0] st_state;
    logic ic_v, ic_iss;
    logic [PA_W-1:0] ic_pa;
    logic dir;
    logic [1:0] gap;
    dcec_kind_t [EC_PIPE-1:0] pipe;
  } dcec_state_t;

  dcec_state_t s_q;
  dcec_state_t n;
  logic [DATA_W-1:0] dmem [2**(IDX_W+1)];       // 16 KB as 1024 sub-blocks
  logic [DATA_W-1:0] ec_dat_s;
  logic [ECTAG_W-1:0] ec_tag_s;
  logic [1:0] ec_size_s;
  logic [DTAG_W-1:0] a_tag, b_tag;
  logic [1:0] a_vld, b_vld, w_vld;
  logic a_hit, b_hit, tag_we, fill_en, dc_st_en, ec_hit, can_rd, can_wr;
  logic [DATA_W-1:0] rtn_data;
  logic [PA_W-1:0] rtn_pa, iss_pa;
  dcec_kind_t last;

  // keep external address inside the configured size
  function automatic logic [PA_W-1:0] ec_span(input logic [PA_W-1:0] pa, input logic [1:0] sz);
    logic [PA_W-1:0] r;
    r = pa;
    if (sz < SZ_4M) r[EC_AMSB] = 1'b0;
    if (sz < SZ_2M) r[EC_AMSB-1] = 1'b0;
    if (sz < SZ_1M) r[EC_AMSB-2] = 1'b0;
    return r;
  endfunction : ec_span

  // pins are resynchronised before any use
  dcec_sync #(.W(DATA_W)) u_sync_dat (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(EC_DATA_I), .q_o(ec_dat_s));
  dcec_sync #(.W(ECTAG_W)) u_sync_tag (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(EC_TAG_I), .q_o(ec_tag_s));
  dcec_sync #(.W(2)) u_sync_sz (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(EC_SIZE_I), .q_o(ec_size_s));

  // tag array: port a loads and stores, port b snoops, fill write alongside
  dcec_tag_ram #(.IW(IDX_W), .TW(DTAG_W)) u_tags (
    .clk_i     (CLK_I),
    .rst_i     (RESET_I),
    .a_idx_i   (LS_VADDR_I[IDX_LSB +: IDX_W]),
    .a_tag_o   (a_tag),
    .a_vld_o   (a_vld),
    .b_idx_i   (SNP_VADDR_I[IDX_LSB +: IDX_W]),
    .b_tag_o   (b_tag),
    .b_vld_o   (b_vld),
    .we_i      (tag_we),
    .w_idx_i   (s_q.ld_va[IDX_LSB +: IDX_W]),
    .w_tag_i   (s_q.ld_pa[PA_W-1:DTAG_LSB]),
    .w_vld_i   (w_vld),
    .inv_i     (b_hit),
    .inv_idx_i (SNP_VADDR_I[IDX_LSB +: IDX_W])
  );

  // physical tag compare on the 41-bit address; loads check their sub-block valid, snoops either valid
  assign a_hit = (a_tag == LS_PADDR_I[PA_W-1:DTAG_LSB]) && a_vld[LS_VADDR_I[SUB_LSB]];
  assign b_hit = SNP_VALID_I && (b_tag == SNP_PADDR_I[PA_W-1:DTAG_LSB]) && (|b_vld);
  assign last  = s_q.pipe[EC_PIPE-1];
  assign can_rd = !s_q.dir || (s_q.gap == EC_TURN);
  assign can_wr = s_q.dir || (s_q.gap == EC_TURN);

  // next state of buffers, external pipeline and pins
  always_comb begin
    n = s_q;
    n.ld_done = 1'b0;
    n.ic_done = 1'b0;
    n.snp_hit = b_hit;
    n.ec_miss = 1'b0;
    n.doe_drv = 1'b0;
    n.toe_drv = 1'b0;
    n.dwr_n = 1'b1;
    n.doe_n = 1'b1;
    n.twr_n = 1'b1;
    n.toe_n = 1'b1;
    n.bwe_n = '1;
    n.pipe = {s_q.pipe[EC_PIPE-2:0], K_NONE};
    if (s_q.gap != EC_TURN) n.gap = s_q.gap + 2'h1;
    fill_en = 1'b0;
    tag_we = 1'b0;
    dc_st_en = 1'b0;
    iss_pa = '0;
    w_vld = s_q.ld_va[SUB_LSB] ? {1'b1, s_q.ld_keep} : {s_q.ld_keep, 1'b1};
    unique case (last)
      K_IC:    rtn_pa = s_q.ic_pa;
      K_ST:    rtn_pa = s_q.st_pa;
      default: rtn_pa = s_q.ld_pa;
    endcase
    // full 22-bit address compare regardless of size, state not invalid
    ec_hit = (ec_tag_s[ECST_LSB-1:0] == rtn_pa[PA_W-1:ECPA_LSB])
             && (ec_tag_s[ECST_MSB:ECST_LSB] != ST_I);
    // pending store bytes overlay a refill of the same sub-block
    rtn_data = ec_dat_s;
    if (s_q.st_v && s_q.st_pa[PA_W-1:SUB_LSB] == s_q.ld_pa[PA_W-1:SUB_LSB]) begin
      for (int b = 0; b < BE_W; b++) begin
        if (s_q.st_mask[b]) rtn_data[8*b +: 8] = s_q.st_data[8*b +: 8];
      end
    end
    // a snoop on the waiting line drops the partner sub-block valid
    if (b_hit && SNP_VADDR_I[IDX_LSB +: IDX_W] == s_q.ld_va[IDX_LSB +: IDX_W]) n.ld_keep = 1'b0;

    // answers leaving the external pipeline
    unique case (last)
      K_LD: begin
        n.ld_done = 1'b1;
        n.ld_emiss = !ec_hit;
        n.ld_data = rtn_data;
        n.ld_v = 1'b0;
        n.ld_rdy = 1'b1;
        fill_en = ec_hit;
        tag_we = ec_hit;
        n.ec_miss = !ec_hit;
      end
      K_IC: begin
        n.ic_done = 1'b1;
        n.ic_hit = ec_hit;
        n.ic_data = ec_dat_s;
        n.ic_v = 1'b0;
        n.ic_rdy = 1'b1;
        n.ec_miss = !ec_hit;
      end
      K_ST: begin
        // only exclusive or modified lines may be written locally
        if (ec_hit && ec_tag_s[ECST_LSB+1]) begin
          n.st_wr = 1'b1;
          n.st_state = ec_tag_s[ECST_MSB:ECST_LSB];
        end else begin
          n.st_v = 1'b0;
          n.st_rdy = 1'b1;
          n.ec_miss = 1'b1;
        end
      end
      K_NONE: begin
      end
    endcase
    if (n.ec_miss) n.ec_miss_pa = rtn_pa;

    // one external access per cycle; a waiting store write goes first
    if (s_q.st_wr && can_wr) begin
      iss_pa = ec_span(s_q.st_pa, ec_size_s);
      n.dwr_n = 1'b0;
      n.doe_n = 1'b0;
      n.doe_drv = 1'b1;
      n.dout = s_q.st_data;
      for (int b = 0; b < BE_W; b++) begin
        n.bwe_n[BE_W-1-b] = !s_q.st_mask[b];
      end
      if (s_q.st_state == ST_E) begin
        n.twr_n = 1'b0;
        n.toe_n = 1'b0;
        n.toe_drv = 1'b1;
        n.tout = {ST_M, s_q.st_pa[PA_W-1:ECPA_LSB]};
      end
      n.st_wr = 1'b0;
      n.st_v = 1'b0;
      n.st_rdy = 1'b1;
      n.dir = 1'b1;
      n.gap = 2'h0;
    end else if (can_rd && ((s_q.ld_v && !s_q.ld_iss) || (s_q.ic_v && !s_q.ic_iss)
                            || (s_q.st_v && !s_q.st_iss && !s_q.st_wr))) begin
      if (s_q.ld_v && !s_q.ld_iss) begin
        iss_pa = ec_span(s_q.ld_pa, ec_size_s);
        n.ld_iss = 1'b1;
        n.pipe[0] = K_LD;
      end else if (s_q.ic_v && !s_q.ic_iss) begin
        iss_pa = ec_span(s_q.ic_pa, ec_size_s);
        n.ic_iss = 1'b1;
        n.pipe[0] = K_IC;
      end else begin
        iss_pa = ec_span(s_q.st_pa, ec_size_s);
        n.st_iss = 1'b1;
        n.pipe[0] = K_ST;
      end
      n.doe_n = 1'b0;
      n.toe_n = 1'b0;
      n.dir = 1'b0;
      n.gap = 2'h0;
    end
    if (n.doe_n == 1'b0) begin
      n.daddr = iss_pa[EC_AMSB:ECD_LSB];
      n.taddr = iss_pa[EC_AMSB:ECT_LSB];
    end

    // new requests from the pipeline
    if (IC_MISS_I && s_q.ic_rdy) begin
      n.ic_v = 1'b1;
      n.ic_iss = 1'b0;
      n.ic_rdy = 1'b0;
      n.ic_pa = IC_PADDR_I;
    end
    if (LS_VALID_I && !LS_WRITE_I && s_q.ld_rdy) begin
      if (a_hit) begin
        n.ld_done = 1'b1;
        n.ld_emiss = 1'b0;
        n.ld_data = dmem[LS_VADDR_I[SUB_LSB +: IDX_W+1]];
      end else begin
        n.ld_v = 1'b1;
        n.ld_iss = 1'b0;
        n.ld_rdy = 1'b0;
        n.ld_va = LS_VADDR_I;
        n.ld_pa = LS_PADDR_I;
        n.ld_keep = (a_tag == LS_PADDR_I[PA_W-1:DTAG_LSB]) && a_vld[!LS_VADDR_I[SUB_LSB]];
      end
    end
    if (LS_VALID_I && LS_WRITE_I && s_q.st_rdy) begin
      dc_st_en = a_hit;
      n.st_v = 1'b1;
      n.st_iss = 1'b0;
      n.st_rdy = 1'b0;
      n.st_pa = LS_PADDR_I;
      n.st_data = LS_WDATA_I;
      n.st_mask = LS_BMASK_I;
    end
  end

  // state register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_q <= '0;
      s_q.ld_rdy <= 1'b1;
      s_q.st_rdy <= 1'b1;
      s_q.ic_rdy <= 1'b1;
      s_q.dwr_n <= 1'b1;
      s_q.doe_n <= 1'b1;
      s_q.twr_n <= 1'b1;
      s_q.toe_n <= 1'b1;
      s_q.bwe_n <= '1;
      s_q.gap <= EC_TURN;
    end else begin
      s_q <= n;
    end
  end

  // sub-block data: refill first, a same-cycle store hit lands on top
  always_ff @(posedge CLK_I) begin
    if (fill_en) begin
      dmem[s_q.ld_va[SUB_LSB +: IDX_W+1]] <= rtn_data;
    end
    if (dc_st_en) begin
      for (int b = 0; b < BE_W; b++) begin
        if (LS_BMASK_I[b]) dmem[LS_VADDR_I[SUB_LSB +: IDX_W+1]][8*b +: 8] <= LS_WDATA_I[8*b +: 8];
      end
    end
  end

  assign LS_LD_READY_O   = s_q.ld_rdy;
  assign LS_ST_READY_O   = s_q.st_rdy;
  assign LD_DONE_O       = s_q.ld_done;
  assign LD_EMISS_O      = s_q.ld_emiss;
  assign LD_DATA_O       = s_q.ld_data;
  assign IC_READY_O      = s_q.ic_rdy;
  assign IC_DONE_O       = s_q.ic_done;
  assign IC_HIT_O        = s_q.ic_hit;
  assign IC_DATA_O       = s_q.ic_data;
  assign SNP_HIT_O       = s_q.snp_hit;
  assign EC_MISS_O       = s_q.ec_miss;
  assign EC_MISS_PA_O    = s_q.ec_miss_pa;
  assign EC_DADDR_O      = s_q.daddr;
  assign EC_TADDR_O      = s_q.taddr;
  assign EC_DATA_O       = s_q.dout;
  assign EC_DATA_OE_O    = s_q.doe_drv;
  assign EC_TAG_O        = s_q.tout;
  assign EC_TAG_OE_O     = s_q.toe_drv;
  assign EC_DWR_N_O      = s_q.dwr_n;
  assign EC_DOE_N_O      = s_q.doe_n;
  assign EC_TWR_N_O      = s_q.twr_n;
  assign EC_TOE_N_O      = s_q.toe_n;
  assign EXT_BYTE_WE_N_O = s_q.bwe_n;

  // checks on the block's own behaviour
  localparam int LAT_C = EC_PIPE;
  logic [BE_W-1:0] bwe_exp;
  always_comb begin
    for (int b = 0; b < BE_W; b++) begin
      bwe_exp[BE_W-1-b] = !s_q.st_mask[b];
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_rd_issue;
    !EC_DOE_N_O && EC_DWR_N_O;
  endsequence
  sequence s_ld_issue;
    $rose(s_q.ld_iss);
  endsequence

  AST_TURNAROUND: assert property (s_rd_issue |=> EC_DWR_N_O [*2])
    else $error("write issued too soon after a read");
  AST_BYTE_WE: assert property ((s_q.st_wr && can_wr) |=> !EC_DWR_N_O && EXT_BYTE_WE_N_O == $past(bwe_exp))
    else $error("byte enables do not match store mask");
  AST_EC_LATENCY: assert property (s_ld_issue |-> ##LAT_C LD_DONE_O)
    else $error("load answer not on the fixed pipeline slot");
  AST_NO_ALLOC: assert property (tag_we |-> last == K_LD && ec_hit)
    else $error("tag written by something other than a load refill");
  AST_STORE_FWD: assert property ((LS_VALID_I && LS_WRITE_I && LS_ST_READY_O) |=> s_q.st_v && !LS_ST_READY_O)
    else $error("store not held for the external cache");
  AST_TAG_MOD: assert property (!EC_TWR_N_O |-> EC_TAG_OE_O && EC_TAG_O[ECST_MSB:ECST_LSB] == ST_M)
    else $error("tag write without modified state");
  AST_SNOOP: assert property (b_hit |=> SNP_HIT_O)
    else $error("snoop hit not reported");
  AST_LOAD_HIT: assert property ((LS_VALID_I && !LS_WRITE_I && LS_LD_READY_O && a_hit) |=> LD_DONE_O && !LD_EMISS_O)
    else $error("data cache hit not answered next cycle");
endmodule : dcec_top

// ===== verification/dcec_ext_sram.sv
// external cache sram model: data and tag arrays behind a three-cycle read pipeline
`timescale 1ns/1ps
module dcec_ext_sram
  import dcec_pkg::*;
(
  input  wire logic               clk_i,   // processor clock
  input  wire logic [ECD_AW-1:0]  daddr_i, // data address
  input  wire logic [ECT_AW-1:0]  taddr_i, // tag address
  input  wire logic [DATA_W-1:0]  data_i,  // write data
  input  wire logic [ECTAG_W-1:0] tag_i,   // write tag
  input  wire logic               dwr_n_i, // data write, low
  input  wire logic               doe_n_i, // data access, low
  input  wire logic               twr_n_i, // tag write, low
  input  wire logic [BE_W-1:0]    bwe_n_i, // byte enables, low
  output logic      [DATA_W-1:0]  data_o,  // read data
  output logic      [ECTAG_W-1:0] tag_o    // read tag
);
  localparam logic [2:0] st_tab [4] = '{ST_E, ST_M, ST_S, ST_I};
  logic [DATA_W-1:0]  dmem [64];
  logic [ECTAG_W-1:0] tmem [16];
  logic [1:0]         rv;
  logic [5:0]         ra [2];
  // lines cycle through states; byte b of entry i holds i
  initial begin
    for (int i = 0; i < 64; i++) dmem[i] = {16{8'(i)}};
    for (int i = 0; i < 16; i++) tmem[i] = {st_tab[i%4], 22'h0};
    data_o = '0;
    tag_o = '0;
    rv = '0;
  end
  // writes land at once; reads answer three cycles after the pins
  always @(posedge clk_i) begin
    rv <= {rv[0], ~doe_n_i & dwr_n_i};
    ra[0] <= daddr_i[5:0];
    ra[1] <= ra[0];
    for (int b = 0; b < BE_W; b++) if (!dwr_n_i && !bwe_n_i[b]) dmem[daddr_i[5:0]][127-8*b-:8] <= data_i[127-8*b-:8];
    if (!twr_n_i) tmem[taddr_i[3:0]] <= tag_i;
    data_o <= rv[1] ? dmem[ra[1]] : ~data_o;
    tag_o <= rv[1] ? tmem[ra[1][5:2]] : ~tag_o;
  end
endmodule : dcec_ext_sram

// ===== verification/data_cache_and_ext_cache_control_test.sv
// self-checking bench for the data cache and external cache controller
`timescale 1ns/1ps
module data_cache_and_ext_cache_control_test
  import dcec_pkg::*;
;
  typedef struct {logic [PA_W-1:0] a; int s; logic em; int lat;} dcec_row_t;
  dcec_row_t rows [5] = '{'{41'h000, 0, 1'b0, 8}, '{41'h000, 0, 1'b0, 1}, '{41'h010, 1, 1'b0, 8},
                          '{41'h0C0, 0, 1'b1, 8}, '{41'h080, 8, 1'b0, 8}};
  logic clk, rst, ls_v, ls_w, ic_v, snp_v, ld_rdy, st_rdy, ld_done, ld_em, ic_rdy, ic_done, ic_hit;
  logic snp_hit, ec_miss, dwr_n, doe_n, twr_n, d_oe, t_oe, toe_n;
  logic [2:0]         woe;
  logic [1:0]         ec_sz;
  logic [PA_W-1:0]    pa, mpa;
  logic [DATA_W-1:0]  wd, ld_data, ic_data, ec_din, ec_dout;
  logic [BE_W-1:0]    bm, bwe_n, wbe;
  logic [ECD_AW-1:0]  daddr, rda;
  logic [ECT_AW-1:0]  taddr;
  logic [ECTAG_W-1:0] ec_tin, ec_tout;
  int error_cnt = 0, checked = 0, misses = 0, cyc = 0;
  // design and external sram model
  dcec_top dcec_top_i (.CLK_I(clk), .RESET_I(rst), .LS_VALID_I(ls_v), .LS_WRITE_I(ls_w),
    .LS_VADDR_I({3'h0, pa}), .LS_PADDR_I(pa), .LS_WDATA_I(wd), .LS_BMASK_I(bm), .LS_LD_READY_O(ld_rdy),
    .LS_ST_READY_O(st_rdy), .LD_DONE_O(ld_done), .LD_EMISS_O(ld_em), .LD_DATA_O(ld_data), .IC_MISS_I(ic_v),
    .IC_PADDR_I(pa), .IC_READY_O(ic_rdy), .IC_DONE_O(ic_done), .IC_HIT_O(ic_hit), .IC_DATA_O(ic_data),
    .SNP_VALID_I(snp_v), .SNP_VADDR_I({3'h0, pa}), .SNP_PADDR_I(pa), .SNP_HIT_O(snp_hit), .EC_SIZE_I(ec_sz),
    .EC_MISS_O(ec_miss), .EC_MISS_PA_O(mpa), .EC_DADDR_O(daddr), .EC_TADDR_O(taddr), .EC_DATA_I(ec_din),
    .EC_DATA_O(ec_dout), .EC_DATA_OE_O(d_oe), .EC_TAG_I(ec_tin), .EC_TAG_O(ec_tout), .EC_TAG_OE_O(t_oe),
    .EC_DWR_N_O(dwr_n), .EC_DOE_N_O(doe_n), .EC_TWR_N_O(twr_n), .EC_TOE_N_O(toe_n), .EXT_BYTE_WE_N_O(bwe_n));
  dcec_ext_sram dcec_ext_sram_i (.clk_i(clk), .daddr_i(daddr), .taddr_i(taddr), .data_i(ec_dout),
    .tag_i(ec_tout), .dwr_n_i(dwr_n), .doe_n_i(doe_n), .twr_n_i(twr_n), .bwe_n_i(bwe_n), .data_o(ec_din),
    .tag_o(ec_tin));
  // clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // cycle count, write enables and miss pulses, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dwr_n === 1'b0) wbe <= bwe_n;
    if (dwr_n === 1'b0) woe <= {d_oe, t_oe, toe_n};
    if (doe_n === 1'b0) rda <= daddr;
    if (ec_miss === 1'b1) misses <= misses + 1;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  function automatic logic [DATA_W-1:0] mg(int i, logic [BE_W-1:0] m);
    logic [DATA_W-1:0] r;
    r = {16{8'(i)}};
    for (int b = 0; b < BE_W; b++) if (m[b]) r[8*b+:8] = 8'hFF;
    return r;
  endfunction : mg
  task automatic tk(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tk
  task automatic cmp(logic [DATA_W-1:0] g, logic [DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // one load: latency in cycles after the take, miss flag, data
  task automatic ldc(logic [PA_W-1:0] a, int el, logic em, logic [DATA_W-1:0] ed);
    int n;
    while (ld_rdy !== 1'b1) tk(1);
    pa = a;
    ls_v = 1;
    tk(1);
    ls_v = 0;
    for (n = 1; ld_done !== 1'b1 && n < 50; n++) tk(1);
    cmp(n, el);
    cmp(ld_em, em);
    if (!em) cmp(ld_data, ed);
    tk(1);
  endtask : ldc
  // one store of all-ones bytes under a mask
  task automatic st(logic [PA_W-1:0] a, logic [BE_W-1:0] m);
    while (st_rdy !== 1'b1) tk(1);
    pa = a;
    bm = m;
    ls_w = 1;
    ls_v = 1;
    tk(1);
    ls_v = 0;
    ls_w = 0;
    for (int n = 0; st_rdy !== 1'b1 && n < 50; n++) tk(1);
    tk(1);
  endtask : st
  // main sequence
  initial begin
    {rst, ls_v, ls_w, ic_v, snp_v} = 5'h10;
    pa = '0;
    wd = '1;
    bm = '0;
    wbe = '1;
    ec_sz = SZ_4M;
    tk(20);
    rst = 0;
    cmp({ld_rdy, st_rdy, ic_rdy, dwr_n, doe_n, bwe_n}, 21'h1F_FFFF);
    foreach (rows[i]) ldc(rows[i].a, rows[i].lat, rows[i].em, mg(rows[i].s, 0));
    cmp(misses, 1);
    st(41'h040, 16'h0003);
    cmp(wbe, 16'h3FFF);
    cmp(woe, 3'h5);
    ldc(41'h040, 8, 0, mg(4, 16'h0003));
    st(41'h000, 16'h8000);
    cmp(wbe, 16'hFFFE);
    cmp(woe, 3'h6);
    cmp(dcec_ext_sram_i.tmem[0][24:22], ST_M);
    ldc(41'h000, 1, 0, mg(0, 16'h8000));
    st(41'h080, 16'h0001);
    cmp(misses, 2);
    pa = 41'h100;
    ic_v = 1;
    tk(1);
    ic_v = 0;
    for (int n = 0; ic_done !== 1'b1 && n < 50; n++) tk(1);
    cmp({ic_hit, ic_data}, {1'b1, mg(16, 0)});
    pa = 41'h000;
    snp_v = 1;
    tk(1);
    snp_v = 0;
    cmp(snp_hit, 1);
    ldc(41'h000, 8, 0, mg(0, 16'h8000));
    ldc(41'h8_0100, 8, 1, '0);
    cmp(rda, 18'h0_8010);
    cmp(mpa, 41'h8_0100);
    ec_sz = SZ_512K;
    tk(3);
    ldc(41'h8_0100, 8, 1, '0);
    cmp(rda, 18'h0_0010);
    complete_run();
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
endmodule : data_cache_and_ext_cache_control_test
